// >>> hdl/phi_pkg.sv
package phi_pkg;

    // ------------------------------------------------------------
    // operation codes presented at issue
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE,
        OP_TLB_PROBE,
        OP_TLB_READ,
        OP_TLB_WR_IDX,
        OP_TLB_WR_RND,
        OP_CACHE,
        OP_CTRL_WR,
        OP_CTRL_RD,
        OP_LOAD,
        OP_STORE,
        OP_EXC_RET,
        OP_DBG_RET
    } phi_op_e;

    // ------------------------------------------------------------
    // operation groups, one-hot bit positions
    // ------------------------------------------------------------
    localparam int NGRP = 6;
    localparam int G_TLB = 0;
    localparam int G_EHI = 1;
    localparam int G_CACHE = 2;
    localparam int G_CWR = 3;
    localparam int G_CRD = 4;
    localparam int G_LS = 5;
    // producers that a consumer must wait for
    localparam logic [5:0] MASK_HW = 6'h0F;
    localparam logic [5:0] MASK_ALL = 6'h3F;
    // producers left as software-visible hazards
    localparam logic [5:0] MASK_SW = 6'h30;

    // ------------------------------------------------------------
    // implicit events tracked down the pipe
    // ------------------------------------------------------------
    localparam int NEV = 8;
    localparam int E_EXC = 0;
    localparam int E_INT = 1;
    localparam int E_TIM = 2;
    localparam int E_DWAT = 3;
    localparam int E_XRET = 4;
    localparam int E_DRTN = 5;
    localparam int E_DBG = 6;
    localparam int E_IMPR = 7;

    // ------------------------------------------------------------
    // pipeline stage numbers
    // ------------------------------------------------------------
    localparam int STG_EARLY = 0;
    localparam int STG_TIMER_CMP = 3;
    localparam int STG_SAMPLE = 4;
    localparam int STG_VEC_READ = 7;
    localparam int STG_WRITE = 8;
    localparam int STG_LATE = 10;

    // ------------------------------------------------------------
    // control register numbers and selects
    // ------------------------------------------------------------
    localparam logic [4:0] CR_INDEX = 5'h00;
    localparam logic [4:0] CR_RANDOM = 5'h01;
    localparam logic [4:0] CR_ENTRY_LO0 = 5'h02;
    localparam logic [4:0] CR_ENTRY_LO1 = 5'h03;
    localparam logic [4:0] CR_PAGE_MASK = 5'h05;
    localparam logic [4:0] CR_ENTRY_HIGH = 5'h0A;
    localparam logic [4:0] CR_TAG_LOW = 5'h1C;
    localparam logic [4:0] CR_TAG_HIGH = 5'h1D;
    localparam logic [2:0] SEL_ICACHE = 3'h0;
    localparam logic [2:0] SEL_DCACHE = 3'h2;

    // ------------------------------------------------------------
    // resource bits
    // ------------------------------------------------------------
    localparam int RS_TLB = 0;
    localparam int RS_TAGS = 1;
    localparam int RS_TAG_IF = 2;
    localparam int RS_STATUS = 3;
    localparam int RS_RET_PC = 4;
    localparam int RS_INDEX = 5;
    localparam int RS_ENTRY = 6;
    localparam int RS_PC = 7;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_STALLS = 12'h008;
    localparam logic [11:0] REG_HAZARDS = 12'h00C;
    localparam int CTRL_SER_ALL = 0;
    localparam int CTRL_CLR = 1;
    localparam logic CTRL_SER_ALL_RST = 1'b0;

endpackage

// >>> hdl/phi_interlock.sv
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module phi_interlock #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic issue_valid,
    input wire phi_pkg::phi_op_e issue_op,
    input wire logic [4:0] issue_cr_num,
    input wire logic [2:0] issue_cr_sel,
    input wire logic issue_fetch_affect,
    input wire logic issue_single_issue_nop,
    input wire logic issue_uses_fp64,
    input wire logic issue_uses_ext,
    output logic issue_ready,
    output logic issue_alone,
    input wire logic exc_entry,
    input wire logic int_taken,
    input wire logic timer_check,
    input wire logic data_watch_defer,
    input wire logic debug_entry,
    input wire logic debug_imprecise,
    output logic int_sample,
    output logic exc_vec_read,
    output logic exc_state_write,
    output logic exc_pc_write,
    output logic timer_compare,
    output logic timer_pend_set,
    output logic watch_sample,
    output logic watch_defer_write,
    output logic exc_ret_pc_read,
    output logic exc_ret_level_clear,
    output logic dbg_ret_pc_read,
    output logic dbg_ret_state_write,
    output logic dbg_state_write,
    output logic dbg_pc_write,
    output logic impr_sample,
    output logic ctrl_write_commit,
    output logic fp_mode_sample,
    output logic ext_enable_sample,
    output logic fetch_sync_needed,
    output logic [7:0] res_read,
    output logic [7:0] res_write
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [phi_pkg::STG_WRITE:1][phi_pkg::NGRP-1:0] grp;
        logic [phi_pkg::STG_WRITE:1] fsync;
        logic [phi_pkg::STG_LATE:1][phi_pkg::NEV-1:0] ev;
        logic ser_all;
        logic fetch_stale;
        logic [CNT_W-1:0] stalls;
        logic [CNT_W-1:0] hazards;
        logic [31:0] rdata;
        logic err;
        logic [7:0] rd;
        logic [7:0] wr;
    } phi_state_s;

    phi_state_s s_q;
    phi_state_s s_d;
    logic [phi_pkg::NGRP-1:0] gnow;
    logic [phi_pkg::NGRP-1:0] inflight;
    logic [phi_pkg::NGRP-1:0] block_mask;
    logic [phi_pkg::NGRP-1:0] sw_mask;
    logic is_ehi;
    logic stall;
    logic fire;
    logic [7:0] rd_now;
    logic [7:0] wr_now;
    logic setup;
    logic access;
    logic hit;

    // ------------------------------------------------------------
    // group decode and resources
    // ------------------------------------------------------------
    assign is_ehi = issue_cr_num == phi_pkg::CR_ENTRY_HIGH && issue_cr_sel == 3'h0;

    always_comb begin
        gnow = '0;
        rd_now = '0;
        wr_now = '0;
        unique case (issue_op)
            phi_pkg::OP_NONE: begin
            end
            phi_pkg::OP_TLB_PROBE: begin
                gnow[phi_pkg::G_TLB] = 1'b1;
                rd_now = 8'h41;
                wr_now = 8'h20;
            end
            phi_pkg::OP_TLB_READ: begin
                gnow[phi_pkg::G_TLB] = 1'b1;
                rd_now = 8'h21;
                wr_now = 8'h41;
            end
            phi_pkg::OP_TLB_WR_IDX, phi_pkg::OP_TLB_WR_RND: begin
                gnow[phi_pkg::G_TLB] = 1'b1;
                rd_now = 8'h60;
                wr_now = 8'h01;
            end
            phi_pkg::OP_CACHE: begin
                gnow[phi_pkg::G_CACHE] = 1'b1;
                rd_now = 8'h07;
                wr_now = 8'h06;
            end
            phi_pkg::OP_CTRL_WR: begin
                gnow[phi_pkg::G_EHI] = is_ehi;
                gnow[phi_pkg::G_CWR] = !is_ehi;
                wr_now[phi_pkg::RS_TLB] = is_ehi;
                wr_now[phi_pkg::RS_ENTRY] = is_ehi;
                wr_now[phi_pkg::RS_TAG_IF] = issue_cr_num == phi_pkg::CR_TAG_LOW
                    || issue_cr_num == phi_pkg::CR_TAG_HIGH;
            end
            phi_pkg::OP_CTRL_RD: begin
                gnow[phi_pkg::G_CRD] = 1'b1;
            end
            phi_pkg::OP_LOAD, phi_pkg::OP_STORE: begin
                gnow[phi_pkg::G_LS] = 1'b1;
                rd_now = 8'h03;
            end
            phi_pkg::OP_EXC_RET, phi_pkg::OP_DBG_RET: begin
                // returns read control state, so wait like a read
                gnow[phi_pkg::G_CRD] = 1'b1;
                rd_now = 8'h18;
                wr_now = 8'h88;
            end
            default: begin
            end
        endcase
    end

    // ------------------------------------------------------------
    // interlock matrix
    // ------------------------------------------------------------
    always_comb begin
        block_mask = '0;
        sw_mask = '0;
        if (gnow[phi_pkg::G_CACHE]) begin
            block_mask = phi_pkg::MASK_ALL;
        end else if (gnow[phi_pkg::G_TLB] || gnow[phi_pkg::G_CRD] || gnow[phi_pkg::G_LS]) begin
            block_mask = phi_pkg::MASK_HW;
            sw_mask = phi_pkg::MASK_SW;
        end
        // later control writes (G_CWR, G_EHI): no entry in either mask
        inflight = '0;
        for (int k = 1; k <= phi_pkg::STG_WRITE; k++) begin
            inflight = inflight | s_q.grp[k];
        end
    end

    // producers count until they leave stage eight
    assign stall = issue_valid && (|(inflight & block_mask)
        || (s_q.ser_all && |gnow && |inflight));
    assign fire = issue_valid && !stall;
    assign issue_ready = !stall;
    assign issue_alone = issue_valid && issue_single_issue_nop;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit = paddr == phi_pkg::REG_CTRL || paddr == phi_pkg::REG_STATUS
        || paddr == phi_pkg::REG_STALLS || paddr == phi_pkg::REG_HAZARDS;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // stage one takes the issuing op, others shift in order
        s_d.grp[1] = fire ? gnow : '0;
        s_d.fsync[1] = fire && ((issue_op == phi_pkg::OP_CTRL_WR && issue_fetch_affect)
            || issue_op == phi_pkg::OP_TLB_WR_IDX
            || issue_op == phi_pkg::OP_TLB_WR_RND);
        s_d.ev[1] = '0;
        s_d.ev[1][phi_pkg::E_EXC] = exc_entry;
        s_d.ev[1][phi_pkg::E_INT] = int_taken;
        s_d.ev[1][phi_pkg::E_TIM] = timer_check;
        s_d.ev[1][phi_pkg::E_DWAT] = data_watch_defer;
        s_d.ev[1][phi_pkg::E_XRET] = fire && issue_op == phi_pkg::OP_EXC_RET;
        s_d.ev[1][phi_pkg::E_DRTN] = fire && issue_op == phi_pkg::OP_DBG_RET;
        s_d.ev[1][phi_pkg::E_DBG] = debug_entry;
        s_d.ev[1][phi_pkg::E_IMPR] = debug_imprecise;
        for (int k = 2; k <= phi_pkg::STG_WRITE; k++) begin
            s_d.grp[k] = s_q.grp[k-1];
            s_d.fsync[k] = s_q.fsync[k-1];
        end
        for (int k = 2; k <= phi_pkg::STG_LATE; k++) begin
            s_d.ev[k] = s_q.ev[k-1];
        end
        // fetch stays stale until an exception return commits; set wins
        if (s_q.ev[phi_pkg::STG_WRITE][phi_pkg::E_XRET]) begin
            s_d.fetch_stale = 1'b0;
        end
        if (s_q.fsync[phi_pkg::STG_WRITE]) begin
            s_d.fetch_stale = 1'b1;
        end
        s_d.rd = fire ? rd_now : '0;
        s_d.wr = fire ? wr_now : '0;
        if (stall && !(&s_q.stalls)) begin
            s_d.stalls = s_q.stalls + 1'b1;
        end
        if (fire && |(inflight & sw_mask) && !(&s_q.hazards)) begin
            s_d.hazards = s_q.hazards + 1'b1;
        end
        if (setup) begin
            s_d.err = !hit;
            unique case (paddr)
                phi_pkg::REG_CTRL: s_d.rdata = {31'h0, s_q.ser_all};
                phi_pkg::REG_STATUS: s_d.rdata = {29'h0, stall, s_q.fetch_stale, |inflight};
                phi_pkg::REG_STALLS: s_d.rdata = 32'(s_q.stalls);
                phi_pkg::REG_HAZARDS: s_d.rdata = 32'(s_q.hazards);
                default: s_d.rdata = 32'h0;
            endcase
        end
        if (access && pwrite && paddr == phi_pkg::REG_CTRL) begin
            s_d.ser_all = pwdata[phi_pkg::CTRL_SER_ALL];
            if (pwdata[phi_pkg::CTRL_CLR]) begin
                s_d.stalls = '0;
                s_d.hazards = '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ser_all <= phi_pkg::CTRL_SER_ALL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = s_q.rdata;
    assign pslverr = s_q.err && access;
    assign pready = 1'b1;
    assign res_read = s_q.rd;
    assign res_write = s_q.wr;
    assign fetch_sync_needed = s_q.fetch_stale;
    // icache ops get no fetch check
    assign ctrl_write_commit = s_q.grp[phi_pkg::STG_WRITE][phi_pkg::G_CWR]
        || s_q.grp[phi_pkg::STG_WRITE][phi_pkg::G_EHI];
    assign fp_mode_sample = fire && issue_uses_fp64;
    assign ext_enable_sample = fire && issue_uses_ext;
    assign int_sample = s_q.ev[phi_pkg::STG_SAMPLE][phi_pkg::E_INT];
    assign exc_vec_read = |(s_q.ev[phi_pkg::STG_VEC_READ][3:0] & 4'hB);
    assign exc_state_write = |(s_q.ev[phi_pkg::STG_WRITE][3:0] & 4'hB);
    assign exc_pc_write = |(s_q.ev[phi_pkg::STG_LATE][3:0] & 4'hB);
    assign timer_compare = s_q.ev[phi_pkg::STG_TIMER_CMP][phi_pkg::E_TIM];
    assign timer_pend_set = s_q.ev[phi_pkg::STG_SAMPLE][phi_pkg::E_TIM];
    assign watch_sample = s_q.ev[phi_pkg::STG_SAMPLE][phi_pkg::E_DWAT];
    assign watch_defer_write = s_q.ev[phi_pkg::STG_WRITE][phi_pkg::E_DWAT];
    assign exc_ret_pc_read = s_q.ev[phi_pkg::STG_VEC_READ][phi_pkg::E_XRET];
    assign exc_ret_level_clear = s_q.ev[phi_pkg::STG_WRITE][phi_pkg::E_XRET];
    assign dbg_ret_pc_read = s_q.ev[phi_pkg::STG_VEC_READ][phi_pkg::E_DRTN];
    assign dbg_ret_state_write = s_q.ev[phi_pkg::STG_WRITE][phi_pkg::E_DRTN];
    assign dbg_state_write = s_q.ev[phi_pkg::STG_WRITE][phi_pkg::E_DBG]
        || s_q.ev[phi_pkg::STG_WRITE][phi_pkg::E_IMPR];
    assign dbg_pc_write = s_q.ev[phi_pkg::STG_LATE][phi_pkg::E_DBG]
        || s_q.ev[phi_pkg::STG_LATE][phi_pkg::E_IMPR];
    assign impr_sample = s_q.ev[phi_pkg::STG_SAMPLE][phi_pkg::E_IMPR];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_exc_steps;
        ##7 exc_vec_read ##1 exc_state_write ##2 exc_pc_write;
    endsequence
    sequence s_dbg_steps;
        ##8 dbg_state_write ##2 dbg_pc_write;
    endsequence
    sequence s_xret_steps;
        ##7 exc_ret_pc_read ##1 exc_ret_level_clear;
    endsequence
    sequence s_dret_steps;
        ##7 dbg_ret_pc_read ##1 dbg_ret_state_write;
    endsequence
    sequence s_watch_steps;
        ##4 watch_sample ##4 watch_defer_write;
    endsequence
    sequence s_impr_steps;
        ##4 impr_sample ##4 dbg_state_write ##2 dbg_pc_write;
    endsequence

    a_read_after_write: assert property (
        fire && issue_op == phi_pkg::OP_CTRL_WR && !is_ehi
        ##1 issue_valid && issue_op == phi_pkg::OP_CTRL_RD |-> !issue_ready)
        else $error("read issued over pending write");
    a_cache_after_mem: assert property (
        fire && issue_op == phi_pkg::OP_LOAD
        ##1 issue_valid && issue_op == phi_pkg::OP_CACHE |-> !issue_ready)
        else $error("cache op issued over pending load");
    a_write_no_wait: assert property (
        issue_valid && issue_op == phi_pkg::OP_CTRL_WR && !s_q.ser_all |-> issue_ready)
        else $error("control write stalled");
    a_write_stage8: assert property (
        fire && issue_op == phi_pkg::OP_CTRL_WR |-> ##8 ctrl_write_commit)
        else $error("control write not committed at stage eight");
    a_exc_timing: assert property (exc_entry |-> s_exc_steps)
        else $error("exception entry steps misplaced");
    a_int_sample: assert property (int_taken |-> ##4 int_sample)
        else $error("interrupt not sampled at stage four");
    a_timer_timing: assert property (
        timer_check |-> ##3 timer_compare ##1 timer_pend_set)
        else $error("timer compare steps misplaced");
    a_xret_timing: assert property (
        fire && issue_op == phi_pkg::OP_EXC_RET |-> s_xret_steps)
        else $error("exception return steps misplaced");
    a_dbg_timing: assert property (debug_entry |-> s_dbg_steps)
        else $error("debug entry steps misplaced");
    a_fetch_sync: assert property (
        fire && issue_op == phi_pkg::OP_CTRL_WR && issue_fetch_affect
        |-> ##9 fetch_sync_needed)
        else $error("fetch sync flag not raised");
    a_stall_bound: assert property (
        issue_valid && !issue_ready |-> ##[1:9] issue_ready)
        else $error("stall lasted past stage eight drain");
    a_dret_timing: assert property (
        fire && issue_op == phi_pkg::OP_DBG_RET |-> s_dret_steps)
        else $error("debug return steps misplaced");
    a_watch_timing: assert property (data_watch_defer |-> s_watch_steps)
        else $error("deferred watch steps misplaced");
    a_impr_timing: assert property (debug_imprecise |-> s_impr_steps)
        else $error("imprecise debug steps misplaced");
    a_mem_after_hw: assert property (
        fire && (issue_op == phi_pkg::OP_TLB_PROBE || issue_op == phi_pkg::OP_CTRL_WR)
        ##1 issue_valid && (issue_op == phi_pkg::OP_LOAD || issue_op == phi_pkg::OP_STORE)
        |-> !issue_ready)
        else $error("memory op issued over pending producer");

endmodule // phi_interlock

`default_nettype wire

// >>> tb/phi_interlock_bench.sv
`timescale 1ns/1ps
`default_nettype none

module phi_interlock_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic issue_valid = 1'b0;
    phi_pkg::phi_op_e issue_op = phi_pkg::OP_NONE;
    logic [4:0] issue_cr_num = 5'h00;
    logic flags = 1'b0;
    logic issue_ready;
    logic issue_alone;
    logic fp_sample;
    logic ext_sample;
    logic fetch_sync;
    logic [7:0] res_rd;
    logic [7:0] res_wr;
    logic [5:0] mk = 6'h00;
    logic [15:0] strb;
    logic [31:0] rd;
    logic er;
    int error_cnt = 0;
    int checks = 0;

    phi_interlock i_phi_interlock (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .issue_valid(issue_valid), .issue_op(issue_op), .issue_cr_num(issue_cr_num),
        .issue_cr_sel(3'h0), .issue_fetch_affect(flags), .issue_single_issue_nop(flags),
        .issue_uses_fp64(flags), .issue_uses_ext(flags), .issue_ready(issue_ready),
        .issue_alone(issue_alone), .exc_entry(mk[5]), .int_taken(mk[4]),
        .timer_check(mk[3]), .data_watch_defer(mk[2]), .debug_entry(mk[1]),
        .debug_imprecise(mk[0]), .int_sample(strb[15]), .exc_vec_read(strb[14]),
        .exc_state_write(strb[13]), .exc_pc_write(strb[12]), .timer_compare(strb[11]),
        .timer_pend_set(strb[10]), .watch_sample(strb[9]), .watch_defer_write(strb[8]),
        .exc_ret_pc_read(strb[7]), .exc_ret_level_clear(strb[6]),
        .dbg_ret_pc_read(strb[5]), .dbg_ret_state_write(strb[4]),
        .dbg_state_write(strb[3]), .dbg_pc_write(strb[2]), .impr_sample(strb[1]),
        .ctrl_write_commit(strb[0]), .fp_mode_sample(fp_sample),
        .ext_enable_sample(ext_sample), .fetch_sync_needed(fetch_sync),
        .res_read(res_rd), .res_write(res_wr)
    );

    always #2 pclk = ~pclk;

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [7:0] b8(input int i);
        b8 = 8'h01 << i;
    endfunction

    // resources named by the rules, read byte above write byte
    function automatic logic [15:0] res_exp(input phi_pkg::phi_op_e op, input logic [4:0] n);
        logic [7:0] w;
        w = 8'h00;
        if (n == phi_pkg::CR_ENTRY_HIGH) begin
            w = b8(phi_pkg::RS_TLB) | b8(phi_pkg::RS_ENTRY);
        end else if (n == phi_pkg::CR_TAG_LOW || n == phi_pkg::CR_TAG_HIGH) begin
            w = b8(phi_pkg::RS_TAG_IF);
        end
        case (op)
            phi_pkg::OP_TLB_PROBE:
                res_exp = {b8(phi_pkg::RS_TLB) | b8(phi_pkg::RS_ENTRY), b8(phi_pkg::RS_INDEX)};
            phi_pkg::OP_TLB_READ:
                res_exp = {b8(phi_pkg::RS_TLB) | b8(phi_pkg::RS_INDEX),
                    b8(phi_pkg::RS_TLB) | b8(phi_pkg::RS_ENTRY)};
            phi_pkg::OP_TLB_WR_IDX, phi_pkg::OP_TLB_WR_RND:
                res_exp = {b8(phi_pkg::RS_INDEX) | b8(phi_pkg::RS_ENTRY), b8(phi_pkg::RS_TLB)};
            phi_pkg::OP_CACHE:
                res_exp = {b8(phi_pkg::RS_TLB) | b8(phi_pkg::RS_TAGS) | b8(phi_pkg::RS_TAG_IF),
                    b8(phi_pkg::RS_TAGS) | b8(phi_pkg::RS_TAG_IF)};
            phi_pkg::OP_CTRL_WR:
                res_exp = {8'h00, w};
            phi_pkg::OP_LOAD, phi_pkg::OP_STORE:
                res_exp = {b8(phi_pkg::RS_TLB) | b8(phi_pkg::RS_TAGS), 8'h00};
            phi_pkg::OP_EXC_RET, phi_pkg::OP_DBG_RET:
                res_exp = {b8(phi_pkg::RS_STATUS) | b8(phi_pkg::RS_RET_PC),
                    b8(phi_pkg::RS_STATUS) | b8(phi_pkg::RS_PC)};
            default:
                res_exp = 16'h0000;
        endcase
    endfunction

    task automatic complete_run();
        $display("mismatches %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // bus and issue drivers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        chk(32'(n), 32'h0, "apb wait states");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // producer then consumer back to back, count stalled cycles
    task automatic pair(input phi_pkg::phi_op_e a, input logic [4:0] na,
                        input phi_pkg::phi_op_e b, input int exp);
        int n;
        n = 0;
        @(posedge pclk);
        issue_valid <= 1'b1;
        issue_op <= a;
        issue_cr_num <= na;
        @(posedge pclk);
        issue_op <= b;
        issue_cr_num <= 5'h00;
        #1;
        chk({16'h0, res_rd, res_wr}, {16'h0, res_exp(a, na)}, "producer res");
        while (issue_ready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            #1;
            n++;
        end
        @(posedge pclk);
        issue_valid <= 1'b0;
        chk(32'(n), 32'(exp), "stall cycles");
        repeat (12) @(posedge pclk);
    endtask

    // mark or issue in cycle 0, nibble j of exp is delay of strobe j
    task automatic strobe_run(input logic [5:0] m, input phi_pkg::phi_op_e op,
                              input logic [63:0] exp, input logic fs);
        logic v;
        logic [15:0] e;
        v = (op != phi_pkg::OP_NONE);
        @(posedge pclk);
        mk <= m;
        issue_valid <= v;
        issue_op <= op;
        flags <= v;
        #1;
        chk({29'h0, issue_alone, fp_sample, ext_sample}, {29'h0, {3{v}}}, "stage 0");
        @(posedge pclk);
        mk <= 6'h00;
        issue_valid <= 1'b0;
        flags <= 1'b0;
        for (int d = 1; d < 12; d++) begin
            #1;
            if (d == 1) begin
                chk({16'h0, res_rd, res_wr}, {16'h0, res_exp(op, 5'h00)}, "res");
            end
            for (int j = 0; j < 16; j++) begin
                e[j] = (exp[4*j+:4] == 4'(d));
            end
            chk({16'h0, strb}, {16'h0, e}, "strobe timing");
            @(posedge pclk);
        end
        #1;
        chk({31'h0, fetch_sync}, {31'h0, fs}, "fetch sync");
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, phi_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h0, "status after reset");
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped error");
        pair(phi_pkg::OP_CTRL_WR, 5'h00, phi_pkg::OP_CTRL_RD, 8);
        pair(phi_pkg::OP_TLB_PROBE, 5'h00, phi_pkg::OP_LOAD, 8);
        pair(phi_pkg::OP_CACHE, 5'h00, phi_pkg::OP_TLB_READ, 8);
        pair(phi_pkg::OP_CTRL_WR, phi_pkg::CR_ENTRY_HIGH, phi_pkg::OP_STORE, 8);
        pair(phi_pkg::OP_CTRL_WR, phi_pkg::CR_TAG_LOW, phi_pkg::OP_CACHE, 8);
        pair(phi_pkg::OP_TLB_WR_IDX, 5'h00, phi_pkg::OP_CACHE, 8);
        pair(phi_pkg::OP_CTRL_RD, 5'h00, phi_pkg::OP_CACHE, 8);
        pair(phi_pkg::OP_LOAD, 5'h00, phi_pkg::OP_CACHE, 8);
        pair(phi_pkg::OP_CTRL_RD, 5'h00, phi_pkg::OP_LOAD, 0);
        pair(phi_pkg::OP_STORE, 5'h00, phi_pkg::OP_TLB_WR_IDX, 0);
        pair(phi_pkg::OP_LOAD, 5'h00, phi_pkg::OP_CTRL_RD, 0);
        pair(phi_pkg::OP_TLB_WR_RND, 5'h00, phi_pkg::OP_CTRL_WR, 0);
        pair(phi_pkg::OP_CACHE, 5'h00, phi_pkg::OP_CTRL_WR, 0);
        apb(1'b0, phi_pkg::REG_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h1, "tlb write needs return");
        apb(1'b1, phi_pkg::REG_CTRL, 32'h1);
        apb(1'b0, phi_pkg::REG_CTRL, 32'h0);
        chk({31'h0, rd[0]}, 32'h1, "serialize all bit");
        pair(phi_pkg::OP_CTRL_RD, 5'h00, phi_pkg::OP_LOAD, 8);
        apb(1'b1, phi_pkg::REG_CTRL, 32'h0);
        strobe_run(6'h00, phi_pkg::OP_EXC_RET, 64'h0000_0000_7800_0000, 1'b0);
        strobe_run(6'h20, phi_pkg::OP_NONE, 64'h078A_0000_0000_0000, 1'b0);
        strobe_run(6'h10, phi_pkg::OP_NONE, 64'h478A_0000_0000_0000, 1'b0);
        strobe_run(6'h08, phi_pkg::OP_NONE, 64'h0000_3400_0000_0000, 1'b0);
        strobe_run(6'h04, phi_pkg::OP_NONE, 64'h078A_0048_0000_0000, 1'b0);
        strobe_run(6'h02, phi_pkg::OP_NONE, 64'h0000_0000_0000_8A00, 1'b0);
        strobe_run(6'h01, phi_pkg::OP_NONE, 64'h0000_0000_0000_8A40, 1'b0);
        strobe_run(6'h00, phi_pkg::OP_CTRL_WR, 64'h0000_0000_0000_0008, 1'b1);
        apb(1'b0, phi_pkg::REG_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h1, "status fetch sync");
        strobe_run(6'h00, phi_pkg::OP_EXC_RET, 64'h0000_0000_7800_0000, 1'b0);
        strobe_run(6'h00, phi_pkg::OP_DBG_RET, 64'h0000_0000_0078_0000, 1'b0);
        complete_run();
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        #(20000 * 4);
        error_cnt++;
        complete_run();
    end
endmodule // phi_interlock_bench

`default_nettype wire
